// [bench/ccw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccw_host_model
    import ccw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [2:0] dev,
    input wire logic rd,
    input wire logic [2:0] regno,
    input wire logic [7:0] data,
    output logic word_valid,
    output logic [WORD_W-1:0] word
);
    logic [7:0] clean;

    // Host never sets the reserved divider-register bit
    assign clean = (!rd && regno == REG_POWER_DIVIDER) ? (data & 8'hdf) : data;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            word_valid <= 1'b0;
            word <= 16'h0000;
        end
        else if (go)
        begin
            word_valid <= 1'b1;
            // Don't-care bit toggles so the block cannot lean on it
            word <= {dev, rd, regno, ~word[8], clean};
        end
        else
        begin
            // Idle word churns so a stale word never looks valid
            word_valid <= 1'b0;
            word <= ~word;
        end
    end
endmodule : ccw_host_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
    import ccw_pkg::*;
;
    typedef struct packed {logic [2:0] n; logic [7:0] d; logic [7:0] e;} ccw_row_s;
    typedef struct packed {logic [2:0] dep; logic fir; logic [4:0] n; logic e;} ccw_duty_s;
    logic clk, rst_b, go, rd, word_valid, is_master, filter_overflow, read_valid;
    logic [2:0] dev, regno, cascade_depth, chain_position, own_address;
    logic [7:0] data, read_data, mode_loopback_control, gain_setting_control;
    logic [WORD_W-1:0] word;
    logic receive_amplifier_on, aa_filter_bypass, alternate_input_select, soft_reset_pulse;
    logic fir_bypass, transmit_amplifiers_on, dac_16bit_format, low_power, modulator_stop;
    logic sclk_duty_uneven;
    logic [5:0] divider_n;
    int miscompares = 0;
    int n_tests = 0;
    ccw_row_s rows [12] = '{
        '{REG_ANALOG_PATH, 8'h40, 8'h20}, '{REG_ANALOG_PATH, 8'h20, 8'h10},
        '{REG_ANALOG_PATH, 8'h10, 8'h08}, '{REG_ANALOG_PATH, 8'h04, 8'h04},
        '{REG_ANALOG_PATH, 8'h02, 8'h02}, '{REG_ANALOG_PATH, 8'h01, 8'h01},
        '{REG_POWER_DIVIDER, 8'h80, 8'ha0}, '{REG_POWER_DIVIDER, 8'h40, 8'h60},
        '{REG_POWER_DIVIDER, 8'h1f, 8'h1f}, '{REG_POWER_DIVIDER, 8'h01, 8'h01},
        '{REG_MODE_LOOPBACK, 8'ha5, 8'ha5}, '{REG_GAIN_SETTING, 8'h5a, 8'h5a}};
    ccw_duty_s duty [7] = '{'{3'h4, 1'b0, 5'h03, 1'b1}, '{3'h4, 1'b0, 5'h04, 1'b0},
        '{3'h4, 1'b0, 5'h00, 1'b0}, '{3'h3, 1'b1, 5'h06, 1'b1},
        '{3'h3, 1'b1, 5'h08, 1'b0}, '{3'h3, 1'b0, 5'h06, 1'b0}, '{3'h3, 1'b1, 5'h00, 1'b0}};

    ccw_host_model host (.clk, .rst_b, .go, .dev, .rd, .regno, .data, .word_valid, .word);
    ccw_control_regs DUT (.clk, .rst_b, .word_valid, .word, .is_master, .cascade_depth,
        .chain_position, .filter_overflow, .read_data, .read_valid, .own_address,
        .receive_amplifier_on, .aa_filter_bypass, .alternate_input_select, .soft_reset_pulse,
        .fir_bypass, .transmit_amplifiers_on, .dac_16bit_format, .low_power, .modulator_stop,
        .divider_n, .mode_loopback_control, .gain_setting_control, .sclk_duty_uneven);

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic end_sim;
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // Word reaches the block one edge after go; result sampled just past the taking edge
    task automatic send(input logic [2:0] a, input logic r, input logic [2:0] n,
                        input logic [7:0] d);
        @(posedge clk);
        go <= 1'b1;
        dev <= a;
        rd <= r;
        regno <= n;
        data <= d;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask : send

    task automatic rdchk(input logic [2:0] a, input logic [2:0] n, input logic [7:0] e);
        send(a, 1'b1, n, 8'h00);
        chk("read_valid", 8'h01, {7'h00, read_valid});
        chk("read_data", e, read_data);
    endtask : rdchk

    task automatic refused(input logic [2:0] a, input logic [2:0] n);
        send(a, 1'b1, n, 8'h00);
        chk("read_valid", 8'h00, {7'h00, read_valid});
    endtask : refused

    task automatic strap(input logic m, input logic [2:0] dep, input logic [2:0] pos);
        @(posedge clk);
        is_master <= m;
        cascade_depth <= dep;
        chain_position <= pos;
        repeat (2) @(posedge clk);
    endtask : strap

    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("divider_n", {2'b00, DIV_RESET_VALUE}, {2'b00, divider_n});
        chk("own_address", {5'h00, cascade_depth}, {5'h00, own_address});
        for (int i = 1; i <= 4; i++)
            rdchk(cascade_depth, 3'(i), 8'h00);
    endtask : do_reset

    function automatic logic [7:0] obs(input logic [2:0] n);
        case (n)
            REG_ANALOG_PATH: obs = {2'b00, receive_amplifier_on, aa_filter_bypass,
                alternate_input_select, fir_bypass, transmit_amplifiers_on, dac_16bit_format};
            REG_POWER_DIVIDER: obs = {low_power, modulator_stop, divider_n};
            REG_MODE_LOOPBACK: obs = mode_loopback_control;
            default: obs = gain_setting_control;
        endcase
    endfunction : obs

    initial
    begin
        rst_b = 1'b0;
        go = 1'b0;
        dev = 3'h0;
        rd = 1'b0;
        regno = 3'h0;
        data = 8'h00;
        is_master = 1'b1;
        cascade_depth = 3'h3;
        chain_position = 3'h0;
        filter_overflow = 1'b0;
        do_reset();
        foreach (rows[i])
        begin
            send(3'h3, 1'b0, rows[i].n, rows[i].d);
            repeat (2) @(posedge clk);
            #1;
            chk("controls", rows[i].e, obs(rows[i].n));
            rdchk(3'h3, rows[i].n, rows[i].d);
        end
        send(3'h3, 1'b0, REG_ANALOG_PATH, 8'h08);
        chk("soft_reset_pulse", 8'h01, {7'h00, soft_reset_pulse});
        @(posedge clk);
        #1;
        chk("soft_reset_pulse", 8'h00, {7'h00, soft_reset_pulse});
        rdchk(3'h3, REG_ANALOG_PATH, 8'h00);
        @(posedge clk);
        filter_overflow <= 1'b1;
        @(posedge clk);
        filter_overflow <= 1'b0;
        rdchk(3'h3, REG_ANALOG_PATH, 8'h80);
        rdchk(3'h3, REG_ANALOG_PATH, 8'h00);
        send(3'h2, 1'b0, REG_MODE_LOOPBACK, 8'hff);
        chk("mode_loopback", 8'ha5, mode_loopback_control);
        refused(3'h2, REG_MODE_LOOPBACK);
        refused(3'h3, REG_NOP);
        refused(3'h3, 3'h5);
        rdchk(3'h3, REG_MODE_LOOPBACK, 8'ha5);
        chk("mode_loopback", 8'ha5, mode_loopback_control);
        strap(1'b0, 3'h3, 3'h2);
        chk("own_address", 8'h02, {5'h00, own_address});
        rdchk(3'h2, REG_GAIN_SETTING, 8'h5a);
        refused(3'h3, REG_GAIN_SETTING);
        strap(1'b1, 3'h0, 3'h2);
        chk("own_address", 8'h00, {5'h00, own_address});
        rdchk(3'h0, REG_GAIN_SETTING, 8'h5a);
        foreach (duty[i])
        begin
            strap(1'b1, duty[i].dep, 3'h0);
            send(duty[i].dep, 1'b0, REG_ANALOG_PATH, {5'h00, duty[i].fir, 2'b00});
            send(duty[i].dep, 1'b0, REG_POWER_DIVIDER, {3'h0, duty[i].n});
            repeat (2) @(posedge clk);
            #1;
            chk("sclk_duty_uneven", {7'h00, duty[i].e}, {7'h00, sclk_duty_uneven});
        end
        do_reset();
        end_sim();
    end
endmodule : tb
`default_nettype wire

// [logic/ccw_control_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module ccw_control_regs
    import ccw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic word_valid,
    input wire logic [WORD_W-1:0] word,
    input wire logic is_master,
    input wire logic [2:0] cascade_depth,
    input wire logic [2:0] chain_position,
    input wire logic filter_overflow,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic [2:0] own_address,
    output logic receive_amplifier_on,
    output logic aa_filter_bypass,
    output logic alternate_input_select,
    output logic soft_reset_pulse,
    output logic fir_bypass,
    output logic transmit_amplifiers_on,
    output logic dac_16bit_format,
    output logic low_power,
    output logic modulator_stop,
    output logic [5:0] divider_n,
    output logic [7:0] mode_loopback_control,
    output logic [7:0] gain_setting_control,
    output logic sclk_duty_uneven
);

    logic [7:0] analog_path_reg;
    logic [7:0] power_divider_reg;
    logic [7:0] mode_loopback_reg;
    logic [7:0] gain_setting_reg;
    logic overflow_reg;
    logic soft_reset_reg;
    logic [7:0] read_data_reg;
    logic read_valid_reg;
    logic [2:0] own_addr_reg;
    logic [5:0] divider_reg;
    logic duty_uneven_reg;

    logic hit;
    logic write_hit;
    logic read_hit;
    logic [2:0] reg_sel;
    logic [7:0] wdata;
    logic [7:0] analog_view;

    // Zero field stands for the top count
    function automatic logic [5:0] div_value(input logic [4:0] field);
        div_value = (field == 5'h00) ? DIV_ZERO_VALUE : {1'b0, field};
    endfunction : div_value

    function automatic logic duty_uneven(input logic [2:0] depth, input logic fir_byp,
                                         input logic [5:0] n);
        if ({1'b0, depth} + 4'h1 > CASCADE_EVEN_LIMIT)
        begin
            duty_uneven = n[0];
        end
        else
        begin
            duty_uneven = fir_byp && (n[1:0] != 2'b00);
        end
    endfunction : duty_uneven

    assign reg_sel = word[REG_HI:REG_LO];
    assign wdata = word[DATA_HI:DATA_LO];
    assign hit = word_valid && (word[DEV_HI:DEV_LO] == own_addr_reg);
    assign write_hit = hit && (word[RW_BIT] == RW_WRITE);
    assign read_hit = hit && (word[RW_BIT] != RW_WRITE);
    assign analog_view = {overflow_reg, analog_path_reg[6:4], 1'b0, analog_path_reg[2:0]};

    // Re-sampled every cycle so a late strap settle is picked up
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            own_addr_reg <= 3'h0;
        end
        else
        begin
            // Stand-alone is a master of depth zero, so it lands on 000
            own_addr_reg <= is_master ? cascade_depth : chain_position;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            analog_path_reg <= ANALOG_PATH_RESET;
        end
        else if (write_hit && reg_sel == REG_ANALOG_PATH)
        begin
            // Overflow and reset bits are not stored
            analog_path_reg <= {1'b0, wdata[6:4], 1'b0, wdata[2:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            soft_reset_reg <= 1'b0;
        end
        else
        begin
            soft_reset_reg <= write_hit && reg_sel == REG_ANALOG_PATH
                && wdata[AP_SOFT_RESET];
        end
    end

    // Sticky overflow; a new event beats the read that clears it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            overflow_reg <= 1'b0;
        end
        else if (filter_overflow)
        begin
            overflow_reg <= 1'b1;
        end
        else if (read_hit && reg_sel == REG_ANALOG_PATH)
        begin
            overflow_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_divider_reg <= POWER_DIVIDER_RESET;
        end
        else if (write_hit && reg_sel == REG_POWER_DIVIDER)
        begin
            // Reserved bit held at zero whatever the host sends
            power_divider_reg <= {wdata[7:6], 1'b0, wdata[4:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_loopback_reg <= MODE_LOOPBACK_RESET;
            gain_setting_reg <= GAIN_SETTING_RESET;
        end
        else
        begin
            if (write_hit && reg_sel == REG_MODE_LOOPBACK)
            begin
                mode_loopback_reg <= wdata;
            end
            if (write_hit && reg_sel == REG_GAIN_SETTING)
            begin
                gain_setting_reg <= wdata;
            end
        end
    end

    // Read answer; no-op and unused numbers give no answer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            read_data_reg <= 8'h00;
            read_valid_reg <= 1'b0;
        end
        else
        begin
            read_valid_reg <= 1'b0;
            if (read_hit)
            begin
                case (reg_sel)
                    REG_ANALOG_PATH:
                    begin
                        read_data_reg <= analog_view;
                        read_valid_reg <= 1'b1;
                    end
                    REG_POWER_DIVIDER:
                    begin
                        read_data_reg <= power_divider_reg;
                        read_valid_reg <= 1'b1;
                    end
                    REG_MODE_LOOPBACK:
                    begin
                        read_data_reg <= mode_loopback_reg;
                        read_valid_reg <= 1'b1;
                    end
                    REG_GAIN_SETTING:
                    begin
                        read_data_reg <= gain_setting_reg;
                        read_valid_reg <= 1'b1;
                    end
                    default:
                    begin
                        read_valid_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Divider and duty flag registered to keep outputs glitch free
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divider_reg <= DIV_RESET_VALUE;
            duty_uneven_reg <= 1'b0;
        end
        else
        begin
            divider_reg <= div_value(power_divider_reg[PD_DIV_HI:PD_DIV_LO]);
            duty_uneven_reg <= duty_uneven(cascade_depth, analog_path_reg[AP_FIR_BYPASS],
                div_value(power_divider_reg[PD_DIV_HI:PD_DIV_LO]));
        end
    end

    assign read_data = read_data_reg;
    assign read_valid = read_valid_reg;
    assign own_address = own_addr_reg;
    assign receive_amplifier_on = analog_path_reg[AP_RECEIVE_AMP];
    assign aa_filter_bypass = analog_path_reg[AP_AA_BYPASS];
    assign alternate_input_select = analog_path_reg[AP_ALT_INPUT];
    assign soft_reset_pulse = soft_reset_reg;
    assign fir_bypass = analog_path_reg[AP_FIR_BYPASS];
    assign transmit_amplifiers_on = analog_path_reg[AP_TRANSMIT_AMPS];
    assign dac_16bit_format = analog_path_reg[AP_DAC_16BIT];
    assign low_power = power_divider_reg[PD_LOW_POWER];
    assign modulator_stop = power_divider_reg[PD_MOD_STOP];
    assign divider_n = divider_reg;
    assign mode_loopback_control = mode_loopback_reg;
    assign gain_setting_control = gain_setting_reg;
    assign sclk_duty_uneven = duty_uneven_reg;

    property p_addr_master;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && is_master) ##1 ($stable(cascade_depth) && is_master)
        |-> own_addr_reg == cascade_depth;
    endproperty
    a_addr_master: assert property (p_addr_master) else $error("master address wrong");

    property p_addr_slave;
        @(posedge clk) disable iff (!rst_b)
        (rst_b && !is_master) ##1 (!is_master && $stable(chain_position))
        |-> own_addr_reg == chain_position;
    endproperty
    a_addr_slave: assert property (p_addr_slave) else $error("slave address wrong");

    property p_alone_zero;
        @(posedge clk) disable iff (!rst_b)
        (is_master && cascade_depth == 3'h0) |=> own_addr_reg == 3'h0;
    endproperty
    a_alone_zero: assert property (p_alone_zero) else $error("stand-alone not 000");

    property p_foreign_ignored;
        @(posedge clk) disable iff (!rst_b)
        (word_valid && word[DEV_HI:DEV_LO] != own_addr_reg) |=> !read_valid && !soft_reset_pulse;
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign word acted");

    property p_write_power;
        @(posedge clk) disable iff (!rst_b)
        (write_hit && reg_sel == REG_POWER_DIVIDER)
        |=> low_power == $past(word[PD_LOW_POWER]) && modulator_stop == $past(word[PD_MOD_STOP])
            && power_divider_reg[PD_RESERVED] == 1'b0;
    endproperty
    a_write_power: assert property (p_write_power) else $error("power write lost");

    property p_write_gain;
        @(posedge clk) disable iff (!rst_b)
        (write_hit && reg_sel == REG_GAIN_SETTING) |=> gain_setting_control == $past(wdata);
    endproperty
    a_write_gain: assert property (p_write_gain) else $error("gain write lost");

    property p_read_no_write;
        @(posedge clk) disable iff (!rst_b)
        read_hit |=> $stable(power_divider_reg) && $stable(mode_loopback_reg)
            && $stable(gain_setting_reg);
    endproperty
    a_read_no_write: assert property (p_read_no_write) else $error("read changed a register");

    property p_nop_silent;
        @(posedge clk) disable iff (!rst_b)
        (hit && reg_sel == REG_NOP) |=> !read_valid && !soft_reset_pulse;
    endproperty
    a_nop_silent: assert property (p_nop_silent) else $error("no-op word acted");

    property p_soft_reset_once;
        @(posedge clk) disable iff (!rst_b)
        (write_hit && reg_sel == REG_ANALOG_PATH && wdata[AP_SOFT_RESET])
        ##1 !word_valid |=> !soft_reset_pulse && !analog_path_reg[AP_SOFT_RESET];
    endproperty
    a_soft_reset_once: assert property (p_soft_reset_once) else $error("reset not one-shot");

    property p_soft_reset_fire;
        @(posedge clk) disable iff (!rst_b)
        (write_hit && reg_sel == REG_ANALOG_PATH && wdata[AP_SOFT_RESET]) |=> soft_reset_pulse;
    endproperty
    a_soft_reset_fire: assert property (p_soft_reset_fire) else $error("reset did not fire");

    property p_overflow_sticky;
        @(posedge clk) disable iff (!rst_b)
        (read_hit && reg_sel == REG_ANALOG_PATH && overflow_reg)
        |=> read_valid && read_data[AP_OVERFLOW];
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow not seen");

    property p_divider_map;
        @(posedge clk) disable iff (!rst_b)
        $stable(power_divider_reg) ##1 $stable(power_divider_reg) |-> divider_n ==
            ((power_divider_reg[4:0] == 5'h00) ? 6'h20 : {1'b0, power_divider_reg[4:0]});
    endproperty
    a_divider_map: assert property (p_divider_map) else $error("divider value wrong");

    property p_duty_large;
        @(posedge clk) disable iff (!rst_b)
        (cascade_depth > 3'h3 && $stable(cascade_depth) && $stable(power_divider_reg))
        |=> sclk_duty_uneven == divider_n[0];
    endproperty
    a_duty_large: assert property (p_duty_large) else $error("duty flag wrong, wide cascade");

    property p_duty_small;
        @(posedge clk) disable iff (!rst_b)
        (cascade_depth <= 3'h3 && !fir_bypass && $stable(fir_bypass)) |=> !sclk_duty_uneven;
    endproperty
    a_duty_small: assert property (p_duty_small) else $error("duty flag wrong, short cascade");

endmodule : ccw_control_regs
`default_nettype wire

// [logic/ccw_pkg.sv]
`default_nettype none
package ccw_pkg;
    // Control word layout
    localparam int WORD_W = 16;
    localparam int DEV_HI = 15;
    localparam int DEV_LO = 13;
    localparam int RW_BIT = 12;
    localparam int REG_HI = 11;
    localparam int REG_LO = 9;
    localparam int DATA_HI = 7;
    localparam int DATA_LO = 0;
    localparam logic RW_WRITE = 1'b0;

    // Register numbers
    localparam logic [2:0] REG_NOP = 3'h0;
    localparam logic [2:0] REG_ANALOG_PATH = 3'h1;
    localparam logic [2:0] REG_POWER_DIVIDER = 3'h2;
    localparam logic [2:0] REG_MODE_LOOPBACK = 3'h3;
    localparam logic [2:0] REG_GAIN_SETTING = 3'h4;

    // analog_path_control fields
    localparam int AP_OVERFLOW = 7;
    localparam int AP_RECEIVE_AMP = 6;
    localparam int AP_AA_BYPASS = 5;
    localparam int AP_ALT_INPUT = 4;
    localparam int AP_SOFT_RESET = 3;
    localparam int AP_FIR_BYPASS = 2;
    localparam int AP_TRANSMIT_AMPS = 1;
    localparam int AP_DAC_16BIT = 0;

    // power_divider_control fields
    localparam int PD_LOW_POWER = 7;
    localparam int PD_MOD_STOP = 6;
    localparam int PD_RESERVED = 5;
    localparam int PD_DIV_HI = 4;
    localparam int PD_DIV_LO = 0;

    // Reset values
    localparam logic [7:0] ANALOG_PATH_RESET = 8'h00;
    localparam logic [7:0] POWER_DIVIDER_RESET = 8'h00;
    localparam logic [7:0] MODE_LOOPBACK_RESET = 8'h00;
    localparam logic [7:0] GAIN_SETTING_RESET = 8'h00;

    // Divider and duty-cycle figures
    localparam logic [5:0] DIV_ZERO_VALUE = 6'h20;
    localparam logic [5:0] DIV_RESET_VALUE = 6'h20;
    localparam logic [3:0] CASCADE_EVEN_LIMIT = 4'h4;
endpackage : ccw_pkg
`default_nettype wire
